// ==== pkg/csre_regs.vh ====
`ifndef CSRE_REGS_VH
`define CSRE_REGS_VH

// Register byte offsets
`define CSRE_OFS_CTRL      8'h00
`define CSRE_OFS_TGT_INDEX 8'h04
`define CSRE_OFS_TGT_UPPER 8'h08
`define CSRE_OFS_TGT_DATA  8'h0c
`define CSRE_OFS_SAF_INDEX 8'h10
`define CSRE_OFS_SAF_UPPER 8'h14
`define CSRE_OFS_SAF_DATA  8'h18
`define CSRE_OFS_SLEW_MON  8'h1c

// Core control bit positions
`define CSRE_BIT_SAFELOAD  5
`define CSRE_BIT_CLEARREGS 6
`define CSRE_BIT_MEMCLEAR  7
`define CSRE_BIT_COREHOLDN 9
`define CSRE_BIT_SLEWMUTE  11
`define CSRE_BIT_VOLDOWN   12
`define CSRE_BIT_VOLDONE   13
`define CSRE_CTRL_WMASK    13'h1ae0
`define CSRE_CTRL_RESET    13'h0000

// Curve type codes
`define CSRE_CURVE_LIN     2'h0
`define CSRE_CURVE_CDB     2'h1
`define CSRE_CURVE_RC      2'h2
`define CSRE_CURVE_CT      2'h3

// Memory reset contents: linear, speed 5, 1.0 in 5.23
`define CSRE_TGT_RESET     34'h050800000
`define CSRE_SLEW_RESET    28'h0800000
`define CSRE_EXP_SHIFT     5'h04
`define CSRE_CT_MIN_STEPS  14'h0040

// Timing
`define CSRE_CLK_NS        8
`define CSRE_FRAME_NS      20833
`define CSRE_FRAME_CYC     (`CSRE_FRAME_NS / `CSRE_CLK_NS)
`define CSRE_MEMCLR_US     100
`define CSRE_MEMCLR_CYC    ((`CSRE_MEMCLR_US * 1000 + `CSRE_CLK_NS - 1) / `CSRE_CLK_NS)

`endif

// ==== logic/csre_ram.v ====
`timescale 1ns/1ps
module csre_ram #(
  parameter integer WIDTH = 34,
  parameter integer DEPTH = 64,
  parameter integer AW    = 6
) (
  // Clock
  input  wire             mclk,
  // Write port
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  // Read port
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ==== logic/csre_slew_engine.v ====
// Functional notes
// R1 - 64 targets, each with own slew, four curves
// R2 - New target starts ramp, one step per frame
// R3 - 34-bit target: 6 control bits, 28-bit 5.23 data
// R4 - Constant-time: 16-bit 2.14 target, 12-bit position
// R5 - Linear/dB/RC word: curve, speed, target bits
// R6 - Constant-time word: refresh, step code, target, reserved
// R7 - Curve codes: linear, constant-dB, RC, constant-time
// R8 - Constant-dB increment derived from current slew
// R9 - RC increment derived from target minus slew
// R10 - Constant-time linear fixed steps, immune to mute
// R11 - Linear increment 2^13 over 10^((speed-5)/10)
// R12 - Speed code 0 fastest, 15 slowest
// R13 - Refresh bit recomputes step, then self-clears
// R14 - Step count is 2^(code+6)
// R15 - Host writes reserved bits as zero
// R16 - Reset: linear, speed 5, target and slew 1.0
// R17 - Mute forces targets zero, release restores them
// R18 - Host prefers safeload for running updates
// R19 - Bit9 low, bit6 high clears core registers
// R20 - Bit7 memory clear self-clears after 100 us
// R21 - Host load order: hold, fill, clear, release
// R22 - Bit12 ramps volume down, bit13 flags done
// R23 - Safeload transfer completes within one frame
// R24 - Never overshoot; snap to target and hold
// R25 - Constant-time counts steps, stops at count
`timescale 1ns/1ps
`include "csre_regs.vh"
module csre_slew_engine #(
  parameter integer FRAME_CYCLES  = `CSRE_FRAME_CYC,
  parameter integer MEMCLR_CYCLES = `CSRE_MEMCLR_CYC
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        resetn,
  // Avalon-MM slave
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // Core control outputs
  output reg         coreClear,
  output reg         memClearActive,
  output reg         rampDownDone,
  output reg         frameStrobe,
  // Slew value stream
  output reg         slewValid,
  output reg  [5:0]  slewIndex,
  output reg  [27:0] slewValue
);

  localparam [2:0] ST_INIT = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ADDR = 3'h2;
  localparam [2:0] ST_CALC = 3'h3;

  localparam [15:0] FRAME_LAST  = FRAME_CYCLES[15:0] - 16'h0001;
  localparam [15:0] MEMCLR_LAST = MEMCLR_CYCLES[15:0] - 16'h0001;

  // Linear increment per speed code, 5.23 LSBs
  function [28:0] linStep;
    input [3:0] tc;
    begin
      case (tc)
        4'h0:    linStep = 29'h0006531;
        4'h1:    linStep = 29'h0005061;
        4'h2:    linStep = 29'h0003fd9;
        4'h3:    linStep = 29'h00032b7;
        4'h4:    linStep = 29'h0002849;
        4'h5:    linStep = 29'h0002000;
        4'h6:    linStep = 29'h000196b;
        4'h7:    linStep = 29'h0001431;
        4'h8:    linStep = 29'h000100a;
        4'h9:    linStep = 29'h0000cbd;
        4'ha:    linStep = 29'h0000a1f;
        4'hb:    linStep = 29'h000080a;
        4'hc:    linStep = 29'h0000663;
        4'hd:    linStep = 29'h0000512;
        4'he:    linStep = 29'h0000407;
        default: linStep = 29'h0000333;
      endcase
    end
  endfunction

  reg  [2:0]  engSt;
  reg  [5:0]  idx;
  reg  [15:0] frameCnt;
  reg  [15:0] clrCnt;
  reg  [12:0] ctrl;
  reg  [5:0]  tgtIndex;
  reg  [5:0]  tgtUpper;
  reg  [5:0]  safIndex;
  reg  [33:0] safWord;
  reg  [27:0] slewMon;
  reg         frameTick;

  wire        safePend = ctrl[`CSRE_BIT_SAFELOAD];
  wire        slewMute = ctrl[`CSRE_BIT_SLEWMUTE];
  wire        volDown  = ctrl[`CSRE_BIT_VOLDOWN];
  wire        idle     = (engSt == ST_IDLE);
  wire        safeXfer = idle && frameTick && safePend;
  wire        reqWr    = write && waitrequest && !read;
  wire        tgtCommitOk = idle && !safeXfer;
  wire        isTgtData = (address == `CSRE_OFS_TGT_DATA);
  wire        hostAck  = waitrequest && (read || (reqWr && (!isTgtData || tgtCommitOk)));
  wire        hostTgtWr = reqWr && isTgtData && tgtCommitOk;

  // Memory read data
  wire [33:0] rdT;
  wire [27:0] rdS;
  wire [41:0] rdP;

  // Field decode of the stored target word
  wire [1:0]  curve    = rdT[33:32];
  wire [3:0]  speed    = rdT[31:28];
  wire        refresh  = rdT[31];
  wire [2:0]  stepCode = rdT[30:28];
  wire [27:0] ctTarget = {{3{rdT[27]}}, rdT[27:12], 9'h000};
  wire [27:0] curStep  = rdP[41:14];
  wire [13:0] curCnt   = rdP[13:0];
  wire [13:0] nSteps   = `CSRE_CT_MIN_STEPS << stepCode;
  wire [13:0] cntInc   = curCnt + 14'h0001;

  wire        isCt      = (curve == `CSRE_CURVE_CT); // R7
  wire        forceZero = (slewMute && !isCt) || (volDown && idx == 6'h00); // R10 R17 R22
  wire [27:0] effT      = forceZero ? 28'h0000000 : (isCt ? ctTarget : rdT[27:0]);

  wire signed [28:0] diff    = $signed({effT[27], effT}) - $signed({rdS[27], rdS});
  wire        [28:0] absDiff = diff[28] ? (29'h0 - diff) : diff;
  wire        [28:0] absSlew = rdS[27] ? (29'h0 - {rdS[27], rdS}) : {rdS[27], rdS};
  wire        [4:0]  expSh   = {1'b0, speed} + `CSRE_EXP_SHIFT;
  wire        [4:0]  ctSh    = {2'b00, stepCode} + 5'h06;
  wire signed [28:0] ctDiv   = diff >>> ctSh;
  wire        [28:0] cdbInc  = absSlew >> expSh;
  wire        [28:0] rcInc   = absDiff >> expSh;

  reg  [28:0] inc;
  reg  [28:0] stepped;
  reg  [27:0] next_slew;
  reg  [41:0] next_par;
  reg  [33:0] next_tgt;
  reg         next_tgtWe;

  // Increment and next slew value per curve
  always @* begin
    case (curve)
      `CSRE_CURVE_LIN: inc = linStep(speed); // R11 R12
      `CSRE_CURVE_CDB: inc = (cdbInc == 29'h0) ? 29'h0000001 : cdbInc; // R8
      `CSRE_CURVE_RC:  inc = (rcInc == 29'h0) ? 29'h0000001 : rcInc; // R9
      default:         inc = 29'h0000001;
    endcase
    stepped    = diff[28] ? ({rdS[27], rdS} - inc) : ({rdS[27], rdS} + inc);
    next_slew  = rdS;
    next_par   = rdP;
    next_tgt   = rdT;
    next_tgtWe = 1'b0;
    if (isCt) begin
      if (refresh) begin
        next_par   = {ctDiv[27:0], 14'h0000}; // R13
        next_tgt   = {rdT[33:32], 1'b0, rdT[30:12], 12'h000}; // R13
        next_tgtWe = 1'b1;
      end else if (curCnt < nSteps) begin
        next_slew  = (cntInc == nSteps) ? effT : (rdS + curStep); // R10 R14 R24
        next_par   = {curStep, cntInc}; // R25
        next_tgt   = {rdT[33:12], cntInc[11:0]}; // R4
        next_tgtWe = 1'b1;
      end
    end else if (absDiff <= inc) begin
      next_slew = effT; // R24
    end else begin
      next_slew = stepped[27:0]; // R2
    end
  end

  // Target memory write arbitration
  reg        tWe;
  reg [5:0]  tAddr;
  reg [33:0] tData;

  always @* begin
    tWe   = 1'b0;
    tAddr = idx;
    tData = `CSRE_TGT_RESET;
    case (engSt)
      ST_INIT: begin
        tWe = 1'b1; // R16
      end
      ST_CALC: begin
        tWe   = next_tgtWe;
        tData = next_tgt;
      end
      ST_IDLE: begin
        if (safeXfer) begin
          tWe   = 1'b1; // R23
          tAddr = safIndex;
          tData = safWord;
        end else if (hostTgtWr) begin
          tWe   = 1'b1; // R5 R6
          tAddr = tgtIndex;
          tData = {tgtUpper, writedata[27:0]}; // R3
        end
      end
      default: begin
        tWe = 1'b0;
      end
    endcase
  end

  wire        sWe   = (engSt == ST_INIT) || (engSt == ST_CALC);
  wire [27:0] sData = (engSt == ST_INIT) ? `CSRE_SLEW_RESET : next_slew; // R16
  wire [41:0] pData = (engSt == ST_INIT) ? 42'h0 : next_par;

  csre_ram #(.WIDTH(34), .DEPTH(64), .AW(6)) u_tgt ( // R1
    .mclk  (mclk),
    .we    (tWe),
    .waddr (tAddr),
    .wdata (tData),
    .raddr (idx),
    .rdata (rdT)
  );

  csre_ram #(.WIDTH(28), .DEPTH(64), .AW(6)) u_slew (
    .mclk  (mclk),
    .we    (sWe),
    .waddr (idx),
    .wdata (sData),
    .raddr (idx),
    .rdata (rdS)
  );

  csre_ram #(.WIDTH(42), .DEPTH(64), .AW(6)) u_step (
    .mclk  (mclk),
    .we    (sWe),
    .waddr (idx),
    .wdata (pData),
    .raddr (idx),
    .rdata (rdP)
  );

  // Frame divider
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frameCnt  <= 16'h0000;
      frameTick <= 1'b0;
    end else begin
      frameTick <= (frameCnt == FRAME_LAST);
      if (frameCnt == FRAME_LAST) begin
        frameCnt <= 16'h0000;
      end else begin
        frameCnt <= frameCnt + 16'h0001;
      end
    end
  end

  // Sweep over all locations once per frame
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      engSt <= ST_INIT;
      idx   <= 6'h00;
    end else begin
      case (engSt)
        ST_INIT: begin
          idx <= idx + 6'h01;
          if (idx == 6'h3f) begin
            engSt <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (frameTick) begin
            engSt <= ST_ADDR; // R2
            idx   <= 6'h00;
          end
        end
        ST_ADDR: begin
          engSt <= ST_CALC;
        end
        ST_CALC: begin
          idx <= idx + 6'h01;
          engSt <= (idx == 6'h3f) ? ST_IDLE : ST_ADDR;
        end
        default: begin
          engSt <= ST_IDLE;
        end
      endcase
    end
  end

  // Control register, self-clearing bits, memory clear timer
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl     <= `CSRE_CTRL_RESET;
      clrCnt   <= 16'h0000;
      tgtIndex <= 6'h00;
      tgtUpper <= 6'h00;
      safIndex <= 6'h00;
      safWord  <= 34'h0;
    end else begin
      if (safeXfer) begin
        ctrl[`CSRE_BIT_SAFELOAD] <= 1'b0; // R23
      end
      if (ctrl[`CSRE_BIT_MEMCLEAR]) begin
        if (clrCnt == MEMCLR_LAST) begin
          ctrl[`CSRE_BIT_MEMCLEAR] <= 1'b0; // R20
          clrCnt <= 16'h0000;
        end else begin
          clrCnt <= clrCnt + 16'h0001;
        end
      end else begin
        clrCnt <= 16'h0000;
      end
      if (reqWr && hostAck) begin
        case (address)
          `CSRE_OFS_CTRL:      ctrl <= (ctrl & ~`CSRE_CTRL_WMASK) | (writedata[12:0] & `CSRE_CTRL_WMASK);
          `CSRE_OFS_TGT_INDEX: tgtIndex <= writedata[5:0];
          `CSRE_OFS_TGT_UPPER: tgtUpper <= writedata[5:0];
          `CSRE_OFS_SAF_INDEX: safIndex <= writedata[5:0];
          `CSRE_OFS_SAF_UPPER: safWord[33:28] <= writedata[5:0];
          `CSRE_OFS_SAF_DATA:  safWord[27:0] <= writedata[27:0];
          default:             safWord <= safWord;
        endcase
      end
    end
  end

  // Avalon answer: one cycle after a request is seen; target data writes wait until the engine is idle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if (hostAck) begin
      waitrequest <= 1'b0;
      if (read) begin
        case (address)
          `CSRE_OFS_CTRL:      readdata <= {18'h0, rampDownDone, ctrl};
          `CSRE_OFS_TGT_INDEX: readdata <= {26'h0, tgtIndex};
          `CSRE_OFS_TGT_UPPER: readdata <= {26'h0, tgtUpper};
          `CSRE_OFS_SAF_INDEX: readdata <= {26'h0, safIndex};
          `CSRE_OFS_SAF_UPPER: readdata <= {26'h0, safWord[33:28]};
          `CSRE_OFS_SAF_DATA:  readdata <= {4'h0, safWord[27:0]};
          `CSRE_OFS_SLEW_MON:  readdata <= {4'h0, slewMon};
          default:             readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Outputs and status
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      coreClear      <= 1'b0;
      memClearActive <= 1'b0;
      rampDownDone   <= 1'b0;
      frameStrobe    <= 1'b0;
      slewValid      <= 1'b0;
      slewIndex      <= 6'h00;
      slewValue      <= 28'h0000000;
      slewMon        <= `CSRE_SLEW_RESET;
    end else begin
      coreClear      <= !ctrl[`CSRE_BIT_COREHOLDN] && ctrl[`CSRE_BIT_CLEARREGS]; // R19
      memClearActive <= ctrl[`CSRE_BIT_MEMCLEAR]; // R20
      frameStrobe    <= frameTick;
      slewValid      <= (engSt == ST_CALC);
      if (engSt == ST_CALC) begin
        slewIndex <= idx;
        slewValue <= next_slew; // R17
        if (idx == tgtIndex) begin
          slewMon <= next_slew;
        end
      end
      if (!volDown) begin
        rampDownDone <= 1'b0; // R22
      end else if (engSt == ST_CALC && idx == 6'h00 && next_slew == 28'h0000000) begin
        rampDownDone <= 1'b1; // R22
      end
    end
  end

endmodule

// ==== verif/csre_assertions.sv ====
`timescale 1ns/1ps
module csre_checker #(
  parameter integer FRAME_CYCLES  = 300,
  parameter integer MEMCLR_CYCLES = 20
) (
  // Clock and reset
  input wire        mclk,
  input wire        resetn,
  // Register bus
  input wire [7:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Core control and slew stream
  input wire        coreClear,
  input wire        memClearActive,
  input wire        rampDownDone,
  input wire        frameStrobe,
  input wire        slewValid,
  input wire [5:0]  slewIndex,
  input wire [27:0] slewValue
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  reg  [15:0] frameCnt;
  reg         frameSeen;
  reg  [15:0] clrCnt;
  wire        ctrlWr = write && waitrequest && address == 8'h00;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frameCnt <= 16'h0000;
      frameSeen <= 1'b0;
      clrCnt <= 16'h0000;
    end else begin
      frameCnt <= frameStrobe ? 16'h0001 : frameCnt + 16'h0001;
      frameSeen <= frameSeen | frameStrobe;
      clrCnt <= memClearActive ? clrCnt + 16'h0001 : 16'h0000;
    end
  end
  property p_wait_pulse;
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
  property p_core_clear;
    ctrlWr |-> ##2 coreClear == $past(!writedata[9] && writedata[6], 2);
  endproperty
  a_core_clear: assert property (p_core_clear) else $error("core clear wrong");
  property p_memclr_max;
    memClearActive |-> clrCnt <= MEMCLR_CYCLES + 2;
  endproperty
  a_memclr_max: assert property (p_memclr_max) else $error("memory clear too long");
  property p_memclr_min;
    $fell(memClearActive) |-> clrCnt >= MEMCLR_CYCLES - 1;
  endproperty
  a_memclr_min: assert property (p_memclr_min) else $error("memory clear too short");
  property p_vol_up;
    ctrlWr && !writedata[12] |-> ##2 !rampDownDone;
  endproperty
  a_vol_up: assert property (p_vol_up) else $error("ramp done not cleared");
  property p_frame_period;
    frameStrobe && frameSeen |-> frameCnt == FRAME_CYCLES ##1 !frameStrobe;
  endproperty
  a_frame_period: assert property (p_frame_period) else $error("frame period wrong");
  property p_sweep_order;
    slewValid && slewIndex != 6'h3f |-> ##1 !slewValid ##1 slewValid && slewIndex == $past(slewIndex, 2) + 6'h01;
  endproperty
  a_sweep_order: assert property (p_sweep_order) else $error("sweep order wrong");
  property p_unmapped;
    read && waitrequest && address >= 8'h20 |=> !waitrequest && readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_frame: cover property (frameStrobe);
  c_memclr: cover property ($fell(memClearActive));
  c_clear: cover property (coreClear);
  c_vol_done: cover property ($rose(rampDownDone));
endmodule
bind csre_slew_engine csre_checker #(.FRAME_CYCLES(FRAME_CYCLES), .MEMCLR_CYCLES(MEMCLR_CYCLES)) csre_checker_inst (
  .mclk(mclk), .resetn(resetn), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .coreClear(coreClear), .memClearActive(memClearActive),
  .rampDownDone(rampDownDone), .frameStrobe(frameStrobe), .slewValid(slewValid), .slewIndex(slewIndex),
  .slewValue(slewValue));

// ==== verif/csre_host_model.sv ====
`timescale 1ns/1ps
module csre_host_model (
  // Clock and bus answer
  input  wire        mclk,
  input  wire        waitrequest,
  input  wire [31:0] readdata,
  // Bus request
  output reg  [7:0]  address,
  output reg         read,
  output reg         write,
  output reg  [31:0] writedata
);
  reg hung;
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    hung = 1'b0;
  end
  task automatic xfer(input bit rd, input [7:0] a, input [31:0] d, output [31:0] q);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0);
    q = readdata;
    hung = hung | (n >= 1000);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Direct target write: upper six bits, then data commits
  task automatic tgt(input [5:0] loc, input [5:0] upper, input [27:0] data);
    reg [31:0] q;
    xfer(1'b0, 8'h04, {26'h0, loc}, q);
    xfer(1'b0, 8'h08, {26'h0, upper}, q);
    xfer(1'b0, 8'h0c, {4'h0, data}, q);
  endtask
  task automatic ct(input [5:0] loc, input [2:0] code, input [15:0] data);
    tgt(loc, {2'h3, 1'b1, code}, {data, 12'h000});
  endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
  typedef struct packed { logic [5:0] up; logic [27:0] tg, e1, e2; } csre_row_t;
  reg         mclk;
  reg         resetn;
  wire [7:0]  address;
  wire        read;
  wire        write;
  wire [31:0] writedata;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        coreClear;
  wire        memClearActive;
  wire        rampDownDone;
  wire        slewValid;
  wire [5:0]  slewIndex;
  wire [27:0] slewValue;
  int         errors = 0;
  int         num_checks = 0;
  logic [27:0] hist [0:63][$];
  reg  [31:0] q;
  int         n;
  csre_row_t  rows [6] = '{'{6'h05, 28'h0, 28'h7fe000, 28'h7fc000}, '{6'h04, 28'h0, 28'h7fd7b7, 28'h7faf6e},
    '{6'h06, 28'h0, 28'h7fe695, 28'h7fcd2a}, '{6'h15, 28'h0, 28'h7fc000, 28'h7f8020},
    '{6'h25, 28'h400000, 28'h7fe000, 28'h7fc010}, '{6'h05, 28'h7fd000, 28'h7fe000, 28'h7fd000}};
  csre_slew_engine #(.FRAME_CYCLES(300), .MEMCLR_CYCLES(20)) csre_slew_engine_inst (
    .mclk(mclk), .resetn(resetn), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .coreClear(coreClear), .memClearActive(memClearActive),
    .rampDownDone(rampDownDone), .frameStrobe(), .slewValid(slewValid), .slewIndex(slewIndex),
    .slewValue(slewValue));
  csre_host_model host (.mclk(mclk), .waitrequest(waitrequest), .readdata(readdata), .address(address),
    .read(read), .write(write), .writedata(writedata));
  always @(posedge mclk) begin
    if (slewValid === 1'b1) begin
      hist[slewIndex].push_back(slewValue);
    end
  end
  task automatic wait_upd(input int loc, input int cnt);
    int t;
    t = 0;
    while (hist[loc].size() < cnt && t < 400 * cnt) begin
      @(posedge mclk);
      t++;
    end
    if (hist[loc].size() < cnt) begin
      errors++;
      $display("BAD %0t no slew update", $time);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #640000;
    errors++;
    test_done;
  end
  initial begin
    resetn = 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    host.xfer(1'b1, 8'h00, 32'h0, q);
    `CHK(q, 32'h0)
    host.xfer(1'b1, 8'h20, 32'h0, q);
    `CHK(q, 32'h0)
    wait_upd(0, 2);
    `CHK(hist[0][1], 28'h0800000)
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      host.tgt(6'(i + 1), rows[i].up, rows[i].tg);
      hist[i + 1].delete();
      wait_upd(i + 1, 2);
      `CHK(hist[i + 1][0], rows[i].e1)
      `CHK(hist[i + 1][1], rows[i].e2)
    end
    $display("test curve rows done");
    host.xfer(1'b1, 8'h1c, 32'h0, q);
    `CHK(q, 32'h07fd000)
    host.xfer(1'b0, 8'h10, 32'h0000000c, q);
    host.xfer(1'b0, 8'h14, 32'h00000005, q);
    host.xfer(1'b0, 8'h18, 32'h00000000, q);
    host.xfer(1'b0, 8'h00, 32'h00000020, q);
    n = 0;
    q = 32'h00000020;
    while (q[5] === 1'b1 && n < 200) begin
      host.xfer(1'b1, 8'h00, 32'h0, q);
      n++;
    end
    hist[12].delete();
    `CHK(n <= 100, 1'b1)
    wait_upd(12, 2);
    `CHK(hist[12][0], 28'h07fe000)
    `CHK(hist[12][1], 28'h07fc000)
    $display("test safeload done");
    host.ct(6'd10, 3'h0, 16'h2000);
    hist[10].delete();
    host.xfer(1'b0, 8'h00, 32'h0800, q);
    hist[11].delete();
    wait_upd(11, 2);
    `CHK(hist[11][0], 28'h07fe000)
    `CHK(hist[11][1], 28'h07fc000)
    host.xfer(1'b0, 8'h00, 32'h0000, q);
    wait_upd(10, 70);
    n = 0;
    for (int i = 1; i < 70; i++) begin
      n += (hist[10][i] !== hist[10][i - 1]);
    end
    `CHK(n + (hist[10][0] !== 28'h0800000), 64)
    `CHK(hist[10][69], 28'h0400000)
    `CHK(hist[11][hist[11].size() - 1], 28'h0800000)
    $display("test constant time and mute done");
    host.xfer(1'b0, 8'h00, 32'h1000, q);
    hist[0].delete();
    wait_upd(0, 2);
    `CHK(hist[0][0], 28'h07fe000)
    `CHK(hist[0][1], 28'h07fc000)
    host.xfer(1'b0, 8'h00, 32'h1040, q);
    repeat (2) @(posedge mclk);
    `CHK(coreClear, 1'b1)
    host.xfer(1'b0, 8'h00, 32'h10c0, q);
    repeat (2) @(posedge mclk);
    n = 0;
    while (memClearActive === 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    `CHK(n >= 18 && n < 200, 1'b1)
    host.xfer(1'b1, 8'h00, 32'h0, q);
    `CHK(q[7], 1'b0)
    host.xfer(1'b0, 8'h00, 32'h1200, q);
    repeat (2) @(posedge mclk);
    `CHK(coreClear, 1'b0)
    `CHK(rampDownDone, 1'b0)
    host.ct(6'd0, 3'h0, 16'h0000);
    wait_upd(0, hist[0].size() + 66);
    `CHK(rampDownDone, 1'b1)
    `CHK(hist[0][hist[0].size() - 1], 28'h0000000)
    host.tgt(6'd0, 6'h05, 28'h0800000);
    host.xfer(1'b0, 8'h00, 32'h0200, q);
    repeat (2) @(posedge mclk);
    `CHK(rampDownDone, 1'b0)
    wait_upd(0, hist[0].size() + 1);
    hist[0].delete();
    wait_upd(0, 2);
    `CHK(hist[0][1], hist[0][0] + 28'h0002000)
    `CHK(host.hung, 1'b0)
    $display("test core control done");
    test_done;
  end
endmodule
